//--- rtl/homing_defs.svh
// Constants of the homing method sequencer
// Included by the package, the sequencer and the bench
`ifndef HOMING_DEFS_SVH
`define HOMING_DEFS_SVH
`define HOME_METHOD_FWD_FALL 8'sh03
`define HOME_METHOD_REV_RISE 8'sh04
`define HOME_METHOD_REV_FALL 8'sh05
`define HOME_METHOD_FWD_RISE 8'sh06
`define HOME_METHOD_REV_FAR_RISE 8'sh0d
`define HOME_METHOD_HERE 8'sh23
`define HOME_ACCEL_FLOOR 32'h0000_0001
`define HOME_TIME_UNIT_US 32'h0000_0064
`define HOME_CLK_MHZ 32'h0000_0019
`define HOME_UNIT_CYCLES (`HOME_TIME_UNIT_US * `HOME_CLK_MHZ)
`define HOME_LIMIT_RESET 16'hc350
`endif

//--- rtl/homing_pkg.sv
// Types of the homing method sequencer
// No assumptions beyond the constants header
`include "homing_defs.svh"
package homing_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SEARCH,
        ST_DECEL,
        ST_EDGE,
        ST_INDEX,
        ST_DONE,
        ST_FAULT
    } homing_state_e;
endpackage

//--- rtl/homing_sync.sv
// Two-flop synchroniser for the switch and index pins
// Assumes pins are asynchronous to i_clk
`timescale 1ns/10ps
module homing_sync (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Pin and synchronised level
    input wire logic i_pin,
    output logic o_level
);
    typedef struct packed {
        logic s1;
        logic s2;
    } sync_s;
    sync_s q, d;
    always_comb begin
        d = q;
        d.s1 = i_pin;
        d.s2 = q.s1;
    end
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
    assign o_level = q.s2;
endmodule // homing_sync

//--- rtl/homing_method_sequencer.sv
// Homing sequencer: method decode, switch search, edge qualify, index latch
// Assumes position and motion profile are handled by the caller
`timescale 1ns/10ps
`include "homing_defs.svh"
module homing_method_sequencer
    import homing_pkg::*;
#(
    parameter int unsigned UNIT_CYCLES = `HOME_UNIT_CYCLES
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Pins
    input wire logic i_home_switch,
    input wire logic i_index_pulse,
    // Settings
    input wire logic signed [7:0] i_method,
    input wire logic [31:0] i_speed_switch,
    input wire logic [31:0] i_speed_zero,
    input wire logic [31:0] i_accel,
    input wire logic [15:0] i_time_limit,
    // Motion handshake
    input wire logic i_start,
    input wire logic i_decel_done,
    input wire logic [31:0] i_position,
    // Results
    output logic o_busy,
    output logic o_dir_reverse,
    output logic [31:0] o_speed,
    output logic [31:0] o_accel,
    output logic o_decel_req,
    output logic o_home_found,
    output logic [31:0] o_home_position,
    output logic o_refused,
    output logic o_homing_timeout_fault
);
    // Method decode: {valid, reverse, want_rising, home_here}
    function automatic logic [3:0] decode(input logic signed [7:0] m);
        case (m)
            `HOME_METHOD_FWD_FALL: decode = 4'h8;
            `HOME_METHOD_REV_RISE: decode = 4'he;
            `HOME_METHOD_REV_FALL: decode = 4'hc;
            `HOME_METHOD_FWD_RISE: decode = 4'ha;
            `HOME_METHOD_REV_FAR_RISE: decode = 4'he;
            `HOME_METHOD_HERE: decode = 4'h9;
            default: decode = 4'h0;
        endcase
    endfunction

    typedef struct packed {
        homing_state_e st;
        logic rev;
        logic rise;
        logic sw_prev;
        logic idx_prev;
        logic [31:0] unit_cnt;
        logic [15:0] elapsed;
        logic busy;
        logic [31:0] speed;
        logic [31:0] accel;
        logic decel;
        logic found;
        logic [31:0] home_pos;
        logic refused;
        logic fault;
    } seq_s;

    seq_s q, d;
    logic sw;
    logic idx;
    logic [1:0] pins;
    logic [1:0] levels;
    logic [3:0] dec;
    logic sw_edge;

    // Pin synchronisers: bit 0 home switch, bit 1 index pulse
    assign pins = {i_index_pulse, i_home_switch};
    for (genvar g = 0; g < 2; g++) begin : g_sync
        homing_sync homing_sync_i (
            .i_clk(i_clk),
            .i_reset(i_reset),
            .i_pin(pins[g]),
            .o_level(levels[g])
        );
    end
    assign sw = levels[0];
    assign idx = levels[1];

    assign dec = decode(i_method);
    assign sw_edge = q.rise ? (sw && !q.sw_prev) : (!sw && q.sw_prev);

    always_comb begin
        d = q;
        d.sw_prev = sw;
        d.idx_prev = idx;
        d.refused = 1'b0;
        if (q.busy) begin
            if (q.unit_cnt == UNIT_CYCLES - 1) begin
                d.unit_cnt = '0;
                d.elapsed = q.elapsed + 16'h0001;
            end else begin
                d.unit_cnt = q.unit_cnt + 32'h1;
            end
        end
        case (q.st)
            ST_IDLE: begin
                if (i_start) begin
                    d.found = 1'b0;
                    d.fault = 1'b0;
                    d.elapsed = '0;
                    d.unit_cnt = '0;
                    if (!dec[3]) begin
                        d.refused = 1'b1;
                    end else if (dec[0]) begin
                        d.home_pos = i_position;
                        d.found = 1'b1;
                        d.st = ST_DONE;
                    end else begin
                        d.rev = dec[2];
                        d.rise = dec[1];
                        d.accel = (i_accel == 32'h0) ? `HOME_ACCEL_FLOOR : i_accel;
                        d.speed = i_speed_switch;
                        d.busy = 1'b1;
                        d.st = ST_SEARCH;
                    end
                end
            end
            ST_SEARCH: begin
                if (sw) begin
                    d.decel = 1'b1;
                    d.st = ST_DECEL;
                end
            end
            ST_DECEL: begin
                if (i_decel_done) begin
                    d.decel = 1'b0;
                    d.speed = i_speed_zero;
                    d.st = ST_EDGE;
                end
            end
            ST_EDGE: begin
                if (sw_edge) begin
                    d.st = ST_INDEX;
                end
            end
            ST_INDEX: begin
                if (idx && !q.idx_prev) begin
                    d.home_pos = i_position;
                    d.found = 1'b1;
                    d.busy = 1'b0;
                    d.speed = '0;
                    d.st = ST_DONE;
                end
            end
            ST_DONE, ST_FAULT: begin
                if (!i_start) begin
                    d.st = ST_IDLE;
                end
            end
            default: d.st = ST_IDLE;
        endcase
        if (q.busy && q.elapsed > i_time_limit) begin
            d.fault = 1'b1;
            d.busy = 1'b0;
            d.decel = 1'b0;
            d.speed = '0;
            d.st = ST_FAULT;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            q <= '0;
            q.st <= ST_IDLE;
            q.accel <= `HOME_ACCEL_FLOOR;
        end else begin
            q <= d;
        end
    end

    assign o_busy = q.busy;
    assign o_dir_reverse = q.rev;
    assign o_speed = q.speed;
    assign o_accel = q.accel;
    assign o_decel_req = q.decel;
    assign o_home_found = q.found;
    assign o_home_position = q.home_pos;
    assign o_refused = q.refused;
    assign o_homing_timeout_fault = q.fault;

    property p_accel_nonzero;
        @(posedge i_clk) disable iff (i_reset) o_busy |-> o_accel != 32'h0;
    endproperty
    a_accel_nonzero: assert property (p_accel_nonzero) else $error("accel zero");

    property p_refuse;
        @(posedge i_clk) disable iff (i_reset)
            (q.st == ST_IDLE && i_start && !dec[3]) |=> (o_refused && !o_busy);
    endproperty
    a_refuse: assert property (p_refuse) else $error("bad method started");

    property p_here;
        @(posedge i_clk) disable iff (i_reset)
            (q.st == ST_IDLE && i_start && dec == 4'h9)
            |=> (o_home_found && o_home_position == $past(i_position) && !o_busy);
    endproperty
    a_here: assert property (p_here) else $error("here method wrong");

    property p_no_early_home;
        @(posedge i_clk) disable iff (i_reset)
            ($rose(o_home_found) && $past(q.st) != ST_IDLE) |-> ($past(q.st) == ST_INDEX);
    endproperty
    a_no_early_home: assert property (p_no_early_home) else $error("index before edge");

    sequence s_motion_start;
        q.st == ST_IDLE && i_start && dec[3] && !dec[0];
    endsequence
    sequence s_index_seen;
        q.st == ST_INDEX && idx && !q.idx_prev;
    endsequence

    property p_index_latch;
        @(posedge i_clk) disable iff (i_reset)
            s_index_seen |=> (o_home_found && o_home_position == $past(i_position));
    endproperty
    a_index_latch: assert property (p_index_latch) else $error("index not latched");

    property p_search_speed;
        @(posedge i_clk) disable iff (i_reset)
            (q.st == ST_SEARCH) |-> (o_speed == i_speed_switch);
    endproperty
    a_search_speed: assert property (p_search_speed) else $error("search speed");

    property p_decel_block;
        @(posedge i_clk) disable iff (i_reset)
            (q.st == ST_DECEL && !i_decel_done && !d.fault) |=> (q.st == ST_DECEL);
    endproperty
    a_decel_block: assert property (p_decel_block) else $error("left decel early");

    property p_timeout;
        @(posedge i_clk) disable iff (i_reset)
            (o_busy && q.elapsed > i_time_limit) |=> (o_homing_timeout_fault && !o_busy);
    endproperty
    a_timeout: assert property (p_timeout) else $error("timeout missed");

    property p_dir;
        @(posedge i_clk) disable iff (i_reset)
            s_motion_start |=> (o_dir_reverse == $past(dec[2]));
    endproperty
    a_dir: assert property (p_dir) else $error("direction wrong");
endmodule // homing_method_sequencer

//--- tb/homing_axis_model.sv
// Axis model: position, home switch and encoder index pulse
// Assumes the bench presets the position while the axis stands still
`timescale 1ns/10ps
module homing_axis_model (
    // Clock
    input wire logic i_clk,
    // Motion and preset
    input wire logic i_move,
    input wire logic i_rev,
    input wire logic i_load,
    input wire logic [31:0] i_load_pos,
    // Position and pins
    output logic [31:0] o_pos,
    output logic o_home_switch,
    output logic o_index_pulse
);
    logic [2:0] phase = 3'h0;
    initial o_pos = 32'h0;
    // One position step every eight cycles while the sequencer moves
    always @(posedge i_clk) begin
        if (i_load) begin
            o_pos <= i_load_pos;
            phase <= 3'h0;
        end else if (i_move) begin
            phase <= phase + 3'h1;
            if (phase == 3'h7) begin
                o_pos <= i_rev ? o_pos - 32'h1 : o_pos + 32'h1;
            end
        end
    end
    // Switch covers positions 8 to 15 of every 32; index at positions 1 mod 4
    assign o_home_switch = (o_pos[4:0] >= 5'h08) && (o_pos[4:0] < 5'h10);
    assign o_index_pulse = i_move && (o_pos[1:0] == 2'h1) && (phase inside {3'h2, 3'h3});
endmodule // homing_axis_model

//--- tb/homing_method_sequencer_tb_top.sv
// Bench for the homing sequencer with an axis model
// Assumes the profile side is played by the bench through i_decel_done
`timescale 1ns/10ps
`include "homing_defs.svh"
module homing_method_sequencer_tb_top;
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic i_home_switch, i_index_pulse, i_start = 1'b0, i_decel_done = 1'b0;
    logic signed [7:0] i_method = 8'sh00;
    logic [31:0] i_accel = 32'h0, i_position, load_pos = 32'h0;
    logic [15:0] i_time_limit = `HOME_LIMIT_RESET;
    logic load = 1'b0;
    logic o_busy, o_dir_reverse, o_decel_req, o_home_found, o_refused, o_homing_timeout_fault;
    logic [31:0] o_speed, o_accel, o_home_position;
    int err_total = 0;
    int tests_run = 0;
    logic signed [7:0] bad_codes [3] = '{8'sh07, 8'sh0f, 8'sh10};
    always #20 i_clk = ~i_clk;
    homing_method_sequencer #(.UNIT_CYCLES(2)) homing_method_sequencer_i (
        .i_clk(i_clk), .i_reset(i_reset), .i_home_switch(i_home_switch),
        .i_index_pulse(i_index_pulse), .i_method(i_method), .i_speed_switch(32'h0000_0100),
        .i_speed_zero(32'h0000_0010), .i_accel(i_accel), .i_time_limit(i_time_limit),
        .i_start(i_start), .i_decel_done(i_decel_done), .i_position(i_position),
        .o_busy(o_busy), .o_dir_reverse(o_dir_reverse), .o_speed(o_speed), .o_accel(o_accel),
        .o_decel_req(o_decel_req), .o_home_found(o_home_found),
        .o_home_position(o_home_position), .o_refused(o_refused),
        .o_homing_timeout_fault(o_homing_timeout_fault));
    homing_axis_model homing_axis_model_i (
        .i_clk(i_clk), .i_move(o_busy), .i_rev(o_dir_reverse), .i_load(load),
        .i_load_pos(load_pos), .o_pos(i_position), .o_home_switch(i_home_switch),
        .o_index_pulse(i_index_pulse));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("Checks %0d, errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Preset position, let the pin synchronisers settle, then raise start
    task automatic go(input logic signed [7:0] m, input logic [31:0] p0);
        @(negedge i_clk);
        load = 1'b1;
        load_pos = p0;
        i_method = m;
        @(negedge i_clk);
        load = 1'b0;
        repeat (2) @(negedge i_clk);
        i_start = 1'b1;
        @(negedge i_clk);
    endtask
    task automatic run(input logic signed [7:0] m, input logic [31:0] p0, input logic rev,
                       input logic [31:0] hp);
        int n;
        go(m, p0);
        chk(o_busy, 32'h1);
        chk(o_dir_reverse, rev);
        chk(o_speed, 32'h0000_0100);
        chk(o_accel, (i_accel == 32'h0) ? 32'h1 : i_accel);
        for (n = 0; n < 2000 && o_decel_req !== 1'b1; n++) @(negedge i_clk);
        repeat (4) @(negedge i_clk);
        i_decel_done = 1'b1;
        @(negedge i_clk);
        i_decel_done = 1'b0;
        @(negedge i_clk);
        chk(o_decel_req, 32'h0);
        chk(o_speed, 32'h0000_0010);
        for (n = 0; n < 2000 && o_home_found !== 1'b1; n++) @(negedge i_clk);
        chk(o_home_found, 32'h1);
        chk(o_home_position, hp);
        chk(o_busy, 32'h0);
        i_start = 1'b0;
    endtask
    initial begin
        #800000;
        err_total++;
        print_verdict();
    end
    initial begin
        int n;
        repeat (16) @(negedge i_clk);
        i_reset = 1'b0;
        run(`HOME_METHOD_FWD_FALL, 32'h0, 1'b0, 32'h11);
        i_accel = 32'h5;
        run(`HOME_METHOD_FWD_RISE, 32'h0, 1'b0, 32'h29);
        run(`HOME_METHOD_REV_FALL, 32'h3c, 1'b1, 32'h25);
        run(`HOME_METHOD_REV_RISE, 32'h3c, 1'b1, 32'h0d);
        run(`HOME_METHOD_REV_FAR_RISE, 32'h3c, 1'b1, 32'h0d);
        go(`HOME_METHOD_HERE, 32'h4d);
        chk(o_home_found, 32'h1);
        chk(o_home_position, 32'h4d);
        chk(o_busy, 32'h0);
        i_start = 1'b0;
        foreach (bad_codes[k]) begin
            go(bad_codes[k], 32'h0);
            chk(o_refused, 32'h1);
            chk(o_busy, 32'h0);
            i_start = 1'b0;
        end
        i_time_limit = 16'h0003;
        go(`HOME_METHOD_FWD_FALL, 32'h0);
        for (n = 0; n < 100 && o_homing_timeout_fault !== 1'b1; n++) @(negedge i_clk);
        chk(o_homing_timeout_fault, 32'h1);
        chk(o_home_found, 32'h0);
        i_start = 1'b0;
        print_verdict();
    end
endmodule // homing_method_sequencer_tb_top
